// ---- core/scsw_clock_switcher.sv ----
`timescale 1ns/100ps
`default_nettype none

module scsw_clock_switcher (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Oscillators
	input wire logic [scsw_pkg::NSRC-1:0] srcReadyPin,
	output logic [scsw_pkg::FRQ_W-1:0] internalFreqSelect,
	// System clock control
	output logic [scsw_pkg::NSRC-1:0] srcEnable,
	output logic [scsw_pkg::DIV_W-1:0] sysDivider,
	// Derived clocks
	output logic medClk500,
	output logic medClk32,
	output logic slowClk31,
	// Interrupt
	output logic irq
);
	import scsw_pkg::*;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	wire logic setup = psel & ~penable;
	wire logic accW = psel & penable & pwrite;
	wire logic accR = psel & penable & ~pwrite;
	wire logic mapped = hit(paddr, REG_REQ) | hit(paddr, REG_CUR) | hit(paddr, REG_CTRL)
		| hit(paddr, REG_FRQ) | hit(paddr, REG_STAT) | hit(paddr, REG_MASK)
		| hit(paddr, REG_OSC);
	wire logic wrReq = accW & hit(paddr, REG_REQ);
	wire logic wrCtrl = accW & hit(paddr, REG_CTRL);
	wire logic wrFrq = accW & hit(paddr, REG_FRQ);
	wire logic wrMask = accW & hit(paddr, REG_MASK);
	wire logic rdStat = accR & hit(paddr, REG_STAT);

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ---------------------------------------------------------------
	// Ready pin synchronisers
	// ---------------------------------------------------------------
	logic [NSRC-1:0] syncA;
	logic [NSRC-1:0] syncB;
	logic [NSRC-1:0] syncC;
	logic [NSRC-1:0] rdyF;

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_sync
			// A change counts only once the last two stages agree.
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					syncA[gi] <= 1'b0;
					syncB[gi] <= 1'b0;
					syncC[gi] <= 1'b0;
					rdyF[gi] <= 1'b0;
				end else begin
					syncA[gi] <= srcReadyPin[gi];
					syncB[gi] <= syncA[gi];
					syncC[gi] <= syncB[gi];
					if (syncB[gi] == syncC[gi])
						rdyF[gi] <= syncC[gi];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	logic [SRC_W-1:0] reqSrc;
	logic [DIV_W-1:0] reqDiv;
	logic [SRC_W-1:0] curSrc;
	logic [DIV_W-1:0] curDiv;
	logic hold;
	logic [NEV-1:0] mask;
	logic [NEV-1:0] stat;
	logic [FRQ_W-1:0] frqSel;

	// Out-of-range source codes are dropped so the mux never sees them.
	wire logic srcOk = pwdata[REQ_SRC_LSB+:SRC_W] < SRC_W'(NSRC);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reqSrc <= RST_SRC;
			reqDiv <= RST_DIV;
			hold <= 1'b0;
			mask <= '0;
			frqSel <= RST_FRQ;
		end else begin
			if (wrReq && srcOk)
				reqSrc <= pwdata[REQ_SRC_LSB+:SRC_W];
			if (wrReq)
				reqDiv <= pwdata[REQ_DIV_LSB+:DIV_W];
			if (wrCtrl)
				hold <= pwdata[CTRL_HOLD];
			if (wrMask)
				mask <= pwdata[NEV-1:0];
			if (wrFrq)
				frqSel <= pwdata[FRQ_W-1:0];
		end
	end

	assign internalFreqSelect = frqSel;

	// ---------------------------------------------------------------
	// Switch sequencer
	// ---------------------------------------------------------------
	scsw_state_t state;
	scsw_state_t next_state;
	logic [SRC_W-1:0] tgtSrc;
	logic [DIV_W-1:0] tgtDiv;
	logic [1:0] gapCnt;
	logic newRdy;
	logic oscRdyPoll;

	wire logic differ = (reqSrc != curSrc) | (reqDiv != curDiv);
	wire logic reqReady = (reqSrc == curSrc) | (|(scsw_onehot(reqSrc) & rdyF));
	wire logic next_newRdy = (state == SW_WAIT) & differ & reqReady;
	wire logic commit = (state == SW_GAP) & (gapCnt == 2'(GAP_CYC - 1));
	wire logic swEvent = next_newRdy & ~newRdy;

	// Nothing here looks at CPU run or sleep state, so a waiting switch
	// survives sleep and completes even while the CPU is dozing.
	always_comb begin
		next_state = state;
		case (state)
			SW_IDLE: begin
				if (differ)
					next_state = SW_WAIT;
			end
			SW_WAIT: begin
				if (!differ)
					next_state = SW_IDLE;
				else if (newRdy && !hold)
					next_state = SW_GAP;
			end
			SW_GAP: begin
				if (commit)
					next_state = SW_IDLE;
			end
			default: next_state = SW_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= SW_IDLE;
			newRdy <= 1'b0;
			oscRdyPoll <= 1'b0;
		end else begin
			state <= next_state;
			newRdy <= next_newRdy;
			oscRdyPoll <= reqReady;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tgtSrc <= RST_SRC;
			tgtDiv <= RST_DIV;
			gapCnt <= '0;
		end else begin
			// The target trails the request by one cycle until the gap opens, so it is
			// the pair that newRdy was judged on; a later request waits for its own round.
			if (state != SW_GAP && next_state != SW_GAP) begin
				tgtSrc <= reqSrc;
				tgtDiv <= reqDiv;
			end
			gapCnt <= (state == SW_GAP) ? gapCnt + 2'h1 : 2'h0;
		end
	end

	// ---------------------------------------------------------------
	// Clock handover
	// ---------------------------------------------------------------
	// Break before make: on a source change every gate is shut for one cycle of the gap
	// so the old and new clocks never overlap on the system net.
	wire logic [NSRC-1:0] next_srcEnable =
		commit ? scsw_onehot(tgtSrc) :
		(state == SW_GAP && tgtSrc != curSrc) ? '0 : scsw_onehot(curSrc);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			curSrc <= RST_SRC;
			curDiv <= RST_DIV;
			srcEnable <= scsw_onehot(RST_SRC);
		end else begin
			if (commit) begin
				curSrc <= tgtSrc;
				curDiv <= tgtDiv;
			end
			srcEnable <= next_srcEnable;
		end
	end

	assign sysDivider = curDiv;

	// ---------------------------------------------------------------
	// Internal oscillator ready flags
	// ---------------------------------------------------------------
	// The fast oscillator is expected to drop its ready pin when retuned;
	// the flags come back only on the next rising edge of that pin.
	logic fastRdy;
	logic medRdy;
	logic fastPrev;
	wire logic fastRise = rdyF[SRC_FAST] & ~fastPrev;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fastPrev <= 1'b0;
			fastRdy <= 1'b0;
			medRdy <= 1'b0;
		end else begin
			fastPrev <= rdyF[SRC_FAST];
			if (fastRise) begin
				fastRdy <= 1'b1;
				medRdy <= 1'b1;
			end else if (wrFrq) begin
				fastRdy <= 1'b0;
				medRdy <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Derived clocks
	// ---------------------------------------------------------------
	logic [NDIVCLK-1:0] divClk;

	generate
		for (gi = 0; gi < NDIVCLK; gi++) begin : g_div
			logic [CNT_W-1:0] cnt;
			// Medium clocks stall at their level while a retune is pending.
			wire logic run = (gi < 2) ? medRdy : 1'b1;
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					cnt <= '0;
					divClk[gi] <= 1'b0;
				end else if (run) begin
					if (cnt == CNT_W'(HALF_CNT[gi] - 1)) begin
						cnt <= '0;
						divClk[gi] <= ~divClk[gi];
					end else begin
						cnt <= cnt + CNT_W'(1);
					end
				end
			end
		end
	endgenerate

	assign medClk500 = divClk[0];
	assign medClk32 = divClk[1];
	assign slowClk31 = divClk[2];

	// ---------------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------------
	wire logic [NEV-1:0] events = {fastRise & ~fastRdy, swEvent};
	// Only the bits the reader actually saw are cleared; a new set wins.
	wire logic [NEV-1:0] clrMask = rdStat ? prdata[NEV-1:0] : '0;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			stat <= '0;
		else
			stat <= (stat & ~clrMask) | events;
	end

	assign irq = |(stat & mask);

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	logic [31:0] next_prdata;

	always_comb begin
		next_prdata = '0;
		if (hit(paddr, REG_REQ)) begin
			next_prdata[REQ_SRC_LSB+:SRC_W] = reqSrc;
			next_prdata[REQ_DIV_LSB+:DIV_W] = reqDiv;
		end else if (hit(paddr, REG_CUR)) begin
			next_prdata[REQ_SRC_LSB+:SRC_W] = curSrc;
			next_prdata[REQ_DIV_LSB+:DIV_W] = curDiv;
		end else if (hit(paddr, REG_CTRL)) begin
			next_prdata[CTRL_HOLD] = hold;
			next_prdata[CTRL_POLL] = oscRdyPoll;
			next_prdata[CTRL_NOSR] = newRdy;
		end else if (hit(paddr, REG_FRQ)) begin
			next_prdata[FRQ_W-1:0] = frqSel;
		end else if (hit(paddr, REG_STAT)) begin
			next_prdata[NEV-1:0] = stat;
		end else if (hit(paddr, REG_MASK)) begin
			next_prdata[NEV-1:0] = mask;
		end else if (hit(paddr, REG_OSC)) begin
			next_prdata[OSC_FAST] = fastRdy;
			next_prdata[OSC_MED] = medRdy;
			next_prdata[OSC_SRC_LSB+:NSRC] = rdyF;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			prdata <= '0;
		else if (setup)
			prdata <= next_prdata;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_hold_blocks: assert property ((state == SW_WAIT && hold) |=> state != SW_GAP)
		else $error("switch started while hold set");
	a_switch_prompt: assert property ((state == SW_WAIT && newRdy && !hold && differ)
		|=> state == SW_GAP)
		else $error("released switch did not start");
	a_flag_on_ready: assert property ($rose(newRdy) |-> stat[EV_SWITCH])
		else $error("switch flag missing on new ready");
	a_irq_enabled: assert property ((stat[EV_SWITCH] && mask[EV_SWITCH]) |-> irq)
		else $error("enabled switch flag without interrupt");
	a_old_src_kept: assert property (!commit |=> $stable(curSrc) && $stable(curDiv))
		else $error("current selection changed outside commit");
	a_commit_values: assert property (commit |=> curSrc == $past(tgtSrc)
		&& curDiv == $past(tgtDiv) && srcEnable == scsw_onehot(curSrc))
		else $error("commit did not take the target");
	a_gap_dark: assert property ((state == SW_GAP && tgtSrc != curSrc && !commit)
		|=> srcEnable == '0)
		else $error("clock gate open during handover gap");
	a_freq_clears: assert property ((wrFrq && !fastRise) |=> !fastRdy && !medRdy)
		else $error("frequency write left ready set");
	a_med_frozen: assert property (!medRdy |=> $stable(medClk500) && $stable(medClk32))
		else $error("medium clock moved while not ready");
	a_same_src_ready: assert property ((state == SW_WAIT && reqSrc == curSrc && differ)
		|=> newRdy)
		else $error("divider-only request not ready at once");

	c_src_switch: cover property (commit && tgtSrc != curSrc);
	c_hold_release: cover property ((state == SW_WAIT && newRdy && hold) ##1 !hold);
	c_cancel: cover property ((state == SW_WAIT && newRdy) ##1 state == SW_IDLE && !commit);
endmodule

`default_nettype wire

// ---- common/scsw_pkg.sv ----
`default_nettype none

package scsw_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_REQ = 8'h00;
	localparam logic [7:0] REG_CUR = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_FRQ = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_MASK = 8'h14;
	localparam logic [7:0] REG_OSC = 8'h18;

	// ---------------------------------------------------------------
	// Field layout
	// ---------------------------------------------------------------
	localparam int SRC_W = 3;
	localparam int DIV_W = 4;
	localparam int FRQ_W = 4;
	localparam int NSRC = 6;
	localparam int NEV = 2;
	localparam int REQ_SRC_LSB = 0;
	localparam int REQ_DIV_LSB = 4;
	localparam int CTRL_HOLD = 0;
	localparam int CTRL_POLL = 1;
	localparam int CTRL_NOSR = 2;
	localparam int EV_SWITCH = 0;
	localparam int EV_FAST = 1;
	localparam int OSC_FAST = 0;
	localparam int OSC_MED = 1;
	localparam int OSC_SRC_LSB = 8;

	// ---------------------------------------------------------------
	// Source codes and reset values
	// ---------------------------------------------------------------
	localparam logic [SRC_W-1:0] SRC_EXT = 3'h0;
	localparam logic [SRC_W-1:0] SRC_FAST = 3'h1;
	localparam logic [SRC_W-1:0] SRC_SLOW = 3'h2;
	localparam logic [SRC_W-1:0] SRC_SEC = 3'h3;
	localparam logic [SRC_W-1:0] SRC_EXT_PLL4 = 3'h4;
	localparam logic [SRC_W-1:0] SRC_FAST_PLL2 = 3'h5;
	localparam logic [SRC_W-1:0] RST_SRC = SRC_FAST;
	localparam logic [DIV_W-1:0] RST_DIV = 4'h0;
	localparam logic [FRQ_W-1:0] RST_FRQ = 4'h0;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int MED_HI_HZ = 500_000;
	localparam int MED_LO_HZ = 32_000;
	localparam int SLOW_HZ = 31_000;
	localparam int CNT_W = 10;
	localparam int NDIVCLK = 3;
	localparam int HALF_CNT [NDIVCLK] = '{CLK_HZ / (2 * MED_HI_HZ),
		CLK_HZ / (2 * MED_LO_HZ), CLK_HZ / (2 * SLOW_HZ)};
	localparam int GAP_NS = 50;
	localparam int GAP_CYC = (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_GAP} scsw_state_t;

	function automatic logic [NSRC-1:0] scsw_onehot(input logic [SRC_W-1:0] s);
		return NSRC'(1) << s;
	endfunction
endpackage

`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import scsw_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} scsw_row_t;

	// ---------------------------------------------------------------
	// Stimulus and observation
	// ---------------------------------------------------------------
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NSRC-1:0] srcReadyPin = 6'h00;
	logic [FRQ_W-1:0] internalFreqSelect;
	logic [NSRC-1:0] srcEnable;
	logic [DIV_W-1:0] sysDivider;
	logic medClk500;
	logic medClk32;
	logic slowClk31;
	logic irq;
	logic lastErr;
	logic [31:0] d;
	logic m;
	logic m2;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	int tog;
	logic [2:0] order [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
	// Reads of the unmapped word must come back zero and flag an error.
	scsw_row_t rows [7] = '{
		'{REG_MASK, 32'hffffffff, 32'h3, 1'b0},
		'{REG_MASK, 32'h3, 32'h3, 1'b0},
		'{REG_CUR, 32'hff, 32'h1, 1'b0},
		'{REG_CTRL, 32'h1, 32'h3, 1'b0},
		'{REG_CTRL, 32'h0, 32'h2, 1'b0},
		'{REG_OSC, 32'h0, 32'h3f03, 1'b0},
		'{8'h1c, 32'hffffffff, 32'h0, 1'b1}};

	always #12.5 clock = ~clock;

	scsw_clock_switcher scsw_clock_switcher_i (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.srcReadyPin(srcReadyPin), .internalFreqSelect(internalFreqSelect),
		.srcEnable(srcEnable), .sysDivider(sysDivider), .medClk500(medClk500),
		.medClk32(medClk32), .slowClk31(slowClk31), .irq(irq));

	wire logic [2:0] dclk = {slowClk31, medClk32, medClk500};

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// The extra edge after release keeps back-to-back calls from driving psel twice at once.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic waitSw(input logic [5:0] e, input logic [3:0] v);
		int n;
		for (n = 0; n < 60 && !(srcEnable === e && sysDivider === v); n++) begin
			@(posedge clock);
		end
		check(32'(srcEnable), 32'(e));
		check(32'(sysDivider), 32'(v));
	endtask

	// Counts the edges between two toggles of a derived clock, after a first toggle.
	task automatic halfCheck(input int k, input int exp);
		logic v;
		int n;
		v = dclk[k];
		n = 0;
		while (dclk[k] === v && n < 2000) begin
			@(posedge clock);
			n++;
		end
		v = dclk[k];
		n = 0;
		while (dclk[k] === v && n < 2000) begin
			@(posedge clock);
			n++;
		end
		check(32'(n), 32'(exp));
	endtask

	task automatic resetCheck();
		rstn <= 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		check(32'(srcEnable), 32'h2);
		check(32'(sysDivider), 32'h0);
		check(32'(irq), 32'h0);
		apb(1'b0, REG_REQ, 32'h0, d);
		check(d, 32'h1);
		apb(1'b0, REG_CUR, 32'h0, d);
		check(d, 32'h1);
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		@(posedge clock);
		resetCheck();
		srcReadyPin <= 6'h3f;
		repeat (10) @(posedge clock);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].w, d);
			apb(1'b0, rows[i].a, 32'h0, d);
			check(d, rows[i].r);
			check(32'(lastErr), 32'(rows[i].e));
		end
		apb(1'b0, REG_STAT, 32'h0, d);
		foreach (order[i]) begin
			apb(1'b1, REG_REQ, 32'(order[i]), d);
			waitSw(6'h1 << order[i], 4'h0);
			check(32'(irq), 32'h1);
			apb(1'b0, REG_CUR, 32'h0, d);
			check(d, 32'(order[i]));
			apb(1'b0, REG_STAT, 32'h0, d);
			check(d & 32'h1, 32'h1);
			check(32'(irq), 32'h0);
		end
		apb(1'b1, REG_REQ, 32'h31, d);
		waitSw(6'h02, 4'h3);
		apb(1'b0, REG_STAT, 32'h0, d);
		check(d & 32'h1, 32'h1);
		apb(1'b1, REG_CTRL, 32'h1, d);
		apb(1'b1, REG_REQ, 32'h2, d);
		repeat (20) @(posedge clock);
		apb(1'b0, REG_CTRL, 32'h0, d);
		check(d, 32'h7);
		check(32'(srcEnable), 32'h2);
		apb(1'b1, REG_CTRL, 32'h0, d);
		waitSw(6'h04, 4'h0);
		apb(1'b1, REG_CTRL, 32'h1, d);
		apb(1'b1, REG_REQ, 32'h5, d);
		repeat (20) @(posedge clock);
		apb(1'b1, REG_REQ, 32'h2, d);
		apb(1'b1, REG_CTRL, 32'h0, d);
		repeat (20) @(posedge clock);
		check(32'(srcEnable), 32'h4);
		apb(1'b0, REG_CTRL, 32'h0, d);
		check(d, 32'h2);
		apb(1'b1, REG_MASK, 32'h0, d);
		apb(1'b0, REG_STAT, 32'h0, d);
		srcReadyPin[3] <= 1'b0;
		repeat (10) @(posedge clock);
		apb(1'b1, REG_REQ, 32'h3, d);
		repeat (30) @(posedge clock);
		check(32'(srcEnable), 32'h4);
		apb(1'b0, REG_CTRL, 32'h0, d);
		check(d, 32'h0);
		srcReadyPin[3] <= 1'b1;
		waitSw(6'h08, 4'h0);
		check(32'(irq), 32'h0);
		apb(1'b1, REG_MASK, 32'h1, d);
		check(32'(irq), 32'h1);
		apb(1'b0, REG_STAT, 32'h0, d);
		check(32'(irq), 32'h0);
		apb(1'b1, REG_FRQ, 32'h7, d);
		srcReadyPin[1] <= 1'b0;
		check(32'(internalFreqSelect), 32'h7);
		apb(1'b0, REG_OSC, 32'h0, d);
		check(d & 32'h3, 32'h0);
		m = medClk500;
		m2 = medClk32;
		tog = 0;
		repeat (100) begin
			@(posedge clock);
			tog += (medClk500 !== m) + (medClk32 !== m2);
		end
		check(32'(tog), 32'h0);
		srcReadyPin[1] <= 1'b1;
		repeat (10) @(posedge clock);
		apb(1'b0, REG_OSC, 32'h0, d);
		check(d, 32'h3f03);
		apb(1'b0, REG_STAT, 32'h0, d);
		check(d & 32'h2, 32'h2);
		m = medClk500;
		tog = 0;
		repeat (100) begin
			@(posedge clock);
			tog += (medClk500 !== m);
			m = medClk500;
		end
		check(32'(tog >= 2), 32'h1);
		halfCheck(0, CLK_HZ / (2 * MED_HI_HZ));
		halfCheck(1, CLK_HZ / (2 * MED_LO_HZ));
		halfCheck(2, CLK_HZ / (2 * SLOW_HZ));
		resetCheck();
		test_done();
	end
endmodule

`default_nettype wire
